// ---- common/cms_pkg.sv ----
// Constants, register map and types for the clock mode switch controller.
// Assumes one 50 MHz clock and a 32-bit AXI4-Lite register bus.
package cms_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned SUB_CLK_HZ    = 32_768;
  localparam int unsigned SUB_DIV_CYC   = CLK_HZ / SUB_CLK_HZ;
  localparam int unsigned MCS_GUARD_CYC = 8;
  localparam int unsigned TBT_W         = 18;
  localparam int unsigned TBT_IRQ_SHIFT = 10;

  // Register byte offsets
  localparam logic [7:0] CLK_SEL_OFS  = 8'h00;
  localparam logic [7:0] LPM_CTRL_OFS = 8'h04;
  localparam logic [7:0] INT_STAT_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0C;
  localparam logic [7:0] BOOT_INFO_OFS = 8'h10;
  localparam logic [7:0] TBT_CNT_OFS  = 8'h14;

  // clock_select_reg fields
  localparam int unsigned MCS_BIT  = 0;
  localparam int unsigned SCS_BIT  = 1;
  localparam int unsigned MCM_BIT  = 2;
  localparam int unsigned SCM_BIT  = 3;
  localparam int unsigned WSL_BIT  = 4;
  localparam int unsigned WSH_BIT  = 5;
  localparam int unsigned BUSY_BIT = 6;
  localparam logic        MCS_RST  = 1'b1;
  localparam logic        SCS_RST  = 1'b1;
  localparam logic [1:0]  WS_RST   = 2'b11;

  // low_power_mode_ctrl_reg fields
  localparam int unsigned STOP_REQ_BIT = 0;

  // Interrupt status / mask bits
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_TBT_BIT  = 0;
  localparam int unsigned IRQ_MODE_BIT = 1;
  localparam logic [IRQ_W-1:0] IMASK_RST = 2'b00;

  // Hard-wired boot data
  localparam logic [23:0] BOOT_VECTOR = 24'hFF_A000;
  localparam logic [7:0]  BOOT_MODE   = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CMS_SRC_MAIN = 2'b00,
    CMS_SRC_PLL  = 2'b01,
    CMS_SRC_SUB  = 2'b10
  } cms_src_type;

  typedef enum logic [7:0] {
    ST_MAIN     = 8'b0000_0001,
    ST_PLL_WAIT = 8'b0000_0010,
    ST_PLL      = 8'b0000_0100,
    ST_SUB_SW   = 8'b0000_1000,
    ST_SUB      = 8'b0001_0000,
    ST_OSC_WAIT = 8'b0010_0000,
    ST_STOP     = 8'b0100_0000
  } cms_state_type;

  // Clock status travelling to the clock tree
  typedef struct packed {
    cms_src_type src;
    logic        main_osc_en;
    logic        pll_en;
    logic        stop_active;
  } cms_clk_stat_type;

  // Time-base timer state
  typedef struct packed {
    logic [TBT_W-1:0] count;
    logic             tick;
  } cms_tbt_state_type;

endpackage : cms_pkg

// ---- hw/cms_ctrl.sv ----
// Clock mode switch controller: main / PLL / subclock selection, stop mode,
// waits timed on the time-base timer, AXI4-Lite registers and interrupt.
// Assumes one clock; subclock rate is a divided enable of aclk.
//
// Summary of operation
// RULE_01: Clearing main select within eight cycles ignored.
// RULE_02: Setting sub select within subclock cycle ignored.
// RULE_03: Monitor bits show clock actually in effect.
// RULE_04: Time-base timer measures oscillator and PLL waits.
// RULE_05: Timer cleared entering PLL, subclock, stop.
// RULE_06: Software masks timer interrupt during transitions.
// RULE_07: Software makes oscillator wait exceed PLL wait.
// RULE_08: Software requests no change mid transition.
// RULE_09: Standby entry write followed by NOPs, jump.
// RULE_10: Boot vector FFA000, mode byte 00 hardwired.
// RULE_11: Software lets subclock stabilise before switching.
// RULE_12: PLL-to-stop needs wait select 10 or 11.
// RULE_13: Reset starts on main clock, monitors main.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module cms_ctrl
  import cms_pkg::*;
#(
  parameter int unsigned WS0_SHIFT      = 10,
  parameter int unsigned WS1_SHIFT      = 12,
  parameter int unsigned WS2_SHIFT      = 14,
  parameter int unsigned WS3_SHIFT      = 16,
  parameter int unsigned PLL_WAIT_SHIFT = 12
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              wake,
  output cms_clk_stat_type       clk_stat,
  output logic [23:0]            boot_vector,
  output logic [7:0]             boot_mode,
  output logic                   irq
);

  typedef struct packed {
    cms_state_type    state;
    logic             main_clock_select_bit;
    logic             sub_clock_select_bit;
    logic [1:0]       ws;
    logic [3:0]       mcs_guard;
    logic             sub_guard;
    logic             stop_pend;
    logic [10:0]      sub_div;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic             aw_v;
    logic [7:0]       aw_addr;
    logic             w_v;
    logic [31:0]      w_data;
    logic             w_lane0;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    cms_clk_stat_type stat;
    logic [23:0]      vec;
    logic [7:0]       mode;
  } cms_ctrl_state_type;

  cms_ctrl_state_type s_r;
  cms_ctrl_state_type s_nxt;

  logic [TBT_W-1:0] tbt_count;
  logic             tbt_tick;
  logic             tbt_clear;
  logic             tbt_run;
  logic             sub_tick;
  logic             osc_done;
  logic             pll_done;
  logic             main_clock_monitor_bit;
  logic             sub_clock_monitor_bit;
  logic             busy;
  logic             do_write;
  logic [4:0]       ws_shift;

  // RULE_04 timer shared by both waits
  cms_tbt u_tbt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (tbt_run),
    .clear   (tbt_clear),
    .count   (tbt_count),
    .tick    (tbt_tick)
  );

  always_comb begin
    case (s_r.ws)
      2'b00:   ws_shift = 5'(WS0_SHIFT);
      2'b01:   ws_shift = 5'(WS1_SHIFT);
      2'b10:   ws_shift = 5'(WS2_SHIFT);
      default: ws_shift = 5'(WS3_SHIFT);
    endcase
  end

  // RULE_04 wait ends on selected timer bit
  assign osc_done = (tbt_count >= (TBT_W'(1) << ws_shift));
  assign pll_done = (tbt_count >= (TBT_W'(1) << PLL_WAIT_SHIFT));
  assign sub_tick = (s_r.sub_div == 11'(SUB_DIV_CYC - 1));
  assign tbt_run  = !(s_r.state inside {ST_SUB, ST_STOP});

  // RULE_03 monitors follow the running source
  assign main_clock_monitor_bit  = (s_r.stat.src != CMS_SRC_PLL);
  assign sub_clock_monitor_bit  = (s_r.stat.src != CMS_SRC_SUB);
  assign busy = (s_r.state inside {ST_PLL_WAIT, ST_SUB_SW, ST_OSC_WAIT});
  assign do_write = s_r.aw_v && s_r.w_v && !s_r.bvalid;

  always_comb begin
    s_nxt     = s_r;
    tbt_clear = 1'b0;

    // Subclock rate divider
    s_nxt.sub_div = sub_tick ? '0 : s_r.sub_div + 11'd1;
    if (s_r.mcs_guard != '0) begin
      s_nxt.mcs_guard = s_r.mcs_guard - 4'd1;
    end
    if (sub_tick) begin
      s_nxt.sub_guard = 1'b0;
    end

    // AXI write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_v    = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_v     = 1'b1;
      s_nxt.w_data  = s_axi_wdata;
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    if (do_write) begin
      s_nxt.aw_v   = 1'b0;
      s_nxt.w_v    = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = RESP_OKAY;
      case (s_r.aw_addr)
        CLK_SEL_OFS: begin
          if (s_r.w_lane0) begin
            // RULE_01 clear ignored inside guard
            if (s_r.w_data[MCS_BIT]) begin
              s_nxt.main_clock_select_bit       = 1'b1;
              s_nxt.mcs_guard = 4'(MCS_GUARD_CYC);
            end else if (s_r.mcs_guard == '0) begin
              s_nxt.main_clock_select_bit = 1'b0;
            end
            // RULE_02 set ignored inside subclock cycle
            if (!s_r.w_data[SCS_BIT]) begin
              s_nxt.sub_clock_select_bit       = 1'b0;
              s_nxt.sub_guard = s_r.sub_clock_select_bit;
            end else if (!s_r.sub_guard) begin
              s_nxt.sub_clock_select_bit = 1'b1;
            end
            s_nxt.ws = {s_r.w_data[WSH_BIT], s_r.w_data[WSL_BIT]};
          end
        end
        LPM_CTRL_OFS: begin
          // RULE_09 stop entry via control write
          if (s_r.w_lane0 && s_r.w_data[STOP_REQ_BIT]) begin
            s_nxt.stop_pend = 1'b1;
          end
        end
        INT_STAT_OFS: begin
          if (s_r.w_lane0) begin
            s_nxt.istat = s_r.istat & ~s_r.w_data[IRQ_W-1:0];
          end
        end
        INT_MASK_OFS: begin
          if (s_r.w_lane0) begin
            s_nxt.imask = s_r.w_data[IRQ_W-1:0];
          end
        end
        BOOT_INFO_OFS, TBT_CNT_OFS: begin
          s_nxt.bresp = RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    // AXI read, answered one cycle after the address is taken
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      s_nxt.rdata  = '0;
      case (s_axi_araddr)
        CLK_SEL_OFS: begin
          s_nxt.rdata[MCS_BIT]  = s_r.main_clock_select_bit;
          s_nxt.rdata[SCS_BIT]  = s_r.sub_clock_select_bit;
          s_nxt.rdata[MCM_BIT]  = main_clock_monitor_bit;
          s_nxt.rdata[SCM_BIT]  = sub_clock_monitor_bit;
          s_nxt.rdata[WSL_BIT]  = s_r.ws[0];
          s_nxt.rdata[WSH_BIT]  = s_r.ws[1];
          s_nxt.rdata[BUSY_BIT] = busy;
        end
        LPM_CTRL_OFS:  s_nxt.rdata[STOP_REQ_BIT] = s_r.stop_pend;
        INT_STAT_OFS:  s_nxt.rdata[IRQ_W-1:0] = s_r.istat;
        INT_MASK_OFS:  s_nxt.rdata[IRQ_W-1:0] = s_r.imask;
        // RULE_10 hard-wired boot data
        BOOT_INFO_OFS: s_nxt.rdata = {BOOT_MODE, BOOT_VECTOR};
        TBT_CNT_OFS:   s_nxt.rdata[TBT_W-1:0] = tbt_count;
        default:       s_nxt.rresp = RESP_SLVERR;
      endcase
    end

    // Mode sequencer
    case (s_r.state)
      ST_MAIN, ST_PLL: begin
        if (s_r.stop_pend) begin
          // RULE_05 clear on stop entry
          // RULE_12 wake wait relies on wait select
          tbt_clear       = 1'b1;
          s_nxt.stop_pend = 1'b0;
          s_nxt.state     = ST_STOP;
        end else if (!s_r.sub_clock_select_bit) begin
          // RULE_05 clear on subclock entry
          // RULE_11 subclock assumed already stable
          tbt_clear   = 1'b1;
          s_nxt.state = ST_SUB_SW;
        end else if (s_r.state == ST_MAIN && !s_r.main_clock_select_bit) begin
          // RULE_05 clear on main to PLL
          tbt_clear   = 1'b1;
          s_nxt.state = ST_PLL_WAIT;
        end else if (s_r.state == ST_PLL && s_r.main_clock_select_bit) begin
          s_nxt.state             = ST_MAIN;
          s_nxt.stat.src          = CMS_SRC_MAIN;
          s_nxt.istat[IRQ_MODE_BIT] = 1'b1;
        end
      end
      ST_PLL_WAIT: begin
        // RULE_08 requests held until wait ends
        if (pll_done) begin
          s_nxt.state             = ST_PLL;
          s_nxt.stat.src          = CMS_SRC_PLL;
          s_nxt.istat[IRQ_MODE_BIT] = 1'b1;
        end
      end
      ST_SUB_SW: begin
        if (sub_tick) begin
          // RULE_05 clear on subclock mode entry
          // Later oscillator wait then starts from zero
          tbt_clear               = 1'b1;
          s_nxt.state             = ST_SUB;
          s_nxt.stat.src          = CMS_SRC_SUB;
          s_nxt.istat[IRQ_MODE_BIT] = 1'b1;
        end
      end
      ST_SUB: begin
        if (s_r.stop_pend) begin
          tbt_clear       = 1'b1;
          s_nxt.stop_pend = 1'b0;
          s_nxt.state     = ST_STOP;
        end else if (s_r.sub_clock_select_bit) begin
          s_nxt.state = ST_OSC_WAIT;
        end
      end
      ST_STOP: begin
        if (wake) begin
          s_nxt.state = s_r.sub_clock_select_bit ? ST_OSC_WAIT : ST_SUB_SW;
        end
      end
      ST_OSC_WAIT: begin
        // RULE_07 PLL locks within oscillator wait
        if (osc_done) begin
          s_nxt.state             = s_r.main_clock_select_bit ? ST_MAIN : ST_PLL;
          s_nxt.stat.src          = s_r.main_clock_select_bit ? CMS_SRC_MAIN : CMS_SRC_PLL;
          s_nxt.istat[IRQ_MODE_BIT] = 1'b1;
        end
      end
      default: begin
        s_nxt.state    = ST_MAIN;
        s_nxt.stat.src = CMS_SRC_MAIN;
      end
    endcase

    // RULE_06 timer tick raises maskable event
    if (tbt_tick) begin
      s_nxt.istat[IRQ_TBT_BIT] = 1'b1;
    end

    s_nxt.stat.stop_active = (s_nxt.state == ST_STOP);
    s_nxt.stat.main_osc_en = !(s_nxt.state inside {ST_SUB, ST_STOP});
    // PLL kept running while it is still the reported source, except in stop
    s_nxt.stat.pll_en      = (s_nxt.state inside {ST_PLL_WAIT, ST_PLL}) ||
                             (s_nxt.state == ST_OSC_WAIT && !s_nxt.main_clock_select_bit) ||
                             (s_nxt.stat.src == CMS_SRC_PLL && s_nxt.state != ST_STOP);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r                  <= '0;
      // RULE_13 reset on main clock
      s_r.state            <= ST_MAIN;
      s_r.main_clock_select_bit              <= MCS_RST;
      s_r.sub_clock_select_bit              <= SCS_RST;
      s_r.ws               <= WS_RST;
      s_r.imask            <= IMASK_RST;
      s_r.stat.src         <= CMS_SRC_MAIN;
      s_r.stat.main_osc_en <= 1'b1;
      s_r.vec              <= BOOT_VECTOR;
      s_r.mode             <= BOOT_MODE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = !s_r.aw_v && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_v && !s_r.bvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign clk_stat      = s_r.stat;
  assign boot_vector   = s_r.vec;
  assign boot_mode     = s_r.mode;
  assign irq           = |(s_r.istat & s_r.imask);

endmodule : cms_ctrl

// ---- hw/cms_tbt.sv ----
// Time-base timer: free counter with auto clear and interval tick.
// Assumes run is low while the main oscillator is stopped.
`timescale 1ns/1ps
module cms_tbt
  import cms_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             run,
  input  wire logic             clear,
  output logic [TBT_W-1:0]      count,
  output logic                  tick
);

  cms_tbt_state_type s_r;
  cms_tbt_state_type s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (clear) begin
      s_nxt.count = '0;
    end else if (run) begin
      s_nxt.count = s_r.count + {{(TBT_W-1){1'b0}}, 1'b1};
      s_nxt.tick  = (s_nxt.count[TBT_IRQ_SHIFT-1:0] == '0);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.count;
  assign tick  = s_r.tick;

endmodule : cms_tbt

// ---- test/cms_ctrl_asserts.sv ----
// Checker for the clock mode switch controller, bound to its ports.
// Assumes the AXI4-Lite timing and clock status encoding of cms_pkg.
`timescale 1ns/1ps
module cms_ctrl_asserts
  import cms_pkg::*;
#(
  parameter int unsigned WS0_SHIFT      = 10,
  parameter int unsigned PLL_WAIT_SHIFT = 12
)(
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic             wake,
  input wire cms_clk_stat_type clk_stat,
  input wire logic [23:0]      boot_vector,
  input wire logic [7:0]       boot_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_main_to_pll;
    clk_stat.src == CMS_SRC_PLL && $past(clk_stat.src) == CMS_SRC_MAIN;
  endsequence
  sequence s_sub_to_main;
    clk_stat.src == CMS_SRC_MAIN && $past(clk_stat.src) == CMS_SRC_SUB;
  endsequence

  a_boot_fixed: assert property (boot_vector == 24'hFF_A000 && boot_mode == 8'h00)
    else $error("boot outputs differ from fixed values");
  a_reset_main_clock: assert property ($rose(aresetn) |-> clk_stat.src == CMS_SRC_MAIN
    && clk_stat.main_osc_en && !clk_stat.pll_en) else $error("not on main clock after reset");
  a_pll_wait_length: assert property (s_main_to_pll |-> $past(clk_stat.src, 8) == CMS_SRC_MAIN)
    else $error("PLL entered before stabilisation wait");
  a_osc_wait_length: assert property (s_sub_to_main |-> $past(clk_stat.src, 16) == CMS_SRC_SUB)
    else $error("main clock entered before oscillator wait");
  a_pll_src_enabled: assert property (clk_stat.src == CMS_SRC_PLL && !clk_stat.stop_active
    |-> clk_stat.pll_en) else $error("PLL source without PLL enabled");
  a_main_osc_enabled: assert property (clk_stat.src != CMS_SRC_SUB && !clk_stat.stop_active
    |-> clk_stat.main_osc_en) else $error("main source without oscillator");
  a_stop_holds: assert property (clk_stat.stop_active && !wake |=> clk_stat.stop_active)
    else $error("stop left without wake");
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read data dropped");
endmodule : cms_ctrl_asserts

bind cms_ctrl cms_ctrl_asserts #(.WS0_SHIFT(WS0_SHIFT), .PLL_WAIT_SHIFT(PLL_WAIT_SHIFT)) u_asserts (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .wake, .clk_stat, .boot_vector, .boot_mode
);

// ---- test/testbench.sv ----
// Self-checking bench for the clock mode switch controller over AXI4-Lite.
// Assumes the checker is bound from its own file; short wait shifts are used.
`timescale 1ns/1ps
module testbench
  import cms_pkg::*;
;
  localparam logic [4:0] M_SRC = 5'b11000;
  logic             aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic             s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wake, irq;
  logic [7:0]       s_axi_awaddr, s_axi_araddr, boot_mode;
  logic [31:0]      s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, rr;
  logic [23:0]      boot_vector;
  cms_clk_stat_type clk_stat;
  int               err_total, comparisons, cyc;

  cms_ctrl #(.WS0_SHIFT(4), .WS1_SHIFT(5), .WS2_SHIFT(6), .WS3_SHIFT(7), .PLL_WAIT_SHIFT(3)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wake, .clk_stat, .boot_vector, .boot_mode, .irq
  );

  task automatic print_verdict;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er, input logic [3:0] st);
    int   n;
    logic done;
    done = 1'b0;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
        check(32'(s_axi_bresp), 32'(er));
      end
      if (n > 100) begin
        err_total++;
        print_verdict();
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic done;
    done = 1'b0;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
      if (n > 100) begin
        err_total++;
        print_verdict();
      end
    end
  endtask : axi_read

  task automatic wait_stat(input logic [4:0] m, input logic [4:0] e, input int lim);
    cyc = 0;
    while ((clk_stat & m) !== e && cyc < lim) begin
      @(posedge aclk);
      cyc++;
    end
    if (cyc >= lim) begin
      err_total++;
      print_verdict();
    end
  endtask : wait_stat

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, wake} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    err_total = 0;
    comparisons = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check(32'(clk_stat), 32'h0000_0004);
    check({boot_mode, boot_vector}, 32'h00FF_A000);
    axi_read(CLK_SEL_OFS, rd, rr);
    check(rd, 32'h0000_003F);
    axi_read(BOOT_INFO_OFS, rd, rr);
    check(rd, 32'h00FF_A000);
    axi_read(8'h40, rd, rr);
    check(32'(rr), 32'(RESP_SLVERR));
    axi_write(8'h40, 32'h0000_0000, RESP_SLVERR, 4'h1);
    axi_write(BOOT_INFO_OFS, 32'h0000_0000, RESP_OKAY, 4'h1);
    axi_write(CLK_SEL_OFS, 32'h0000_003E, RESP_OKAY, 4'h0);
    axi_read(CLK_SEL_OFS, rd, rr);
    check(rd, 32'h0000_003F);
    axi_write(CLK_SEL_OFS, 32'h0000_003E, RESP_OKAY, 4'h1);
    wait_stat(M_SRC, 5'b01000, 200);
    check(32'(cyc >= 4), 32'h0000_0001);
    axi_read(CLK_SEL_OFS, rd, rr);
    check(rd, 32'h0000_003A);
    axi_write(CLK_SEL_OFS, 32'h0000_003F, RESP_OKAY, 4'h1);
    axi_write(CLK_SEL_OFS, 32'h0000_003E, RESP_OKAY, 4'h1);
    axi_read(CLK_SEL_OFS, rd, rr);
    check(rd, 32'h0000_003F);
    repeat (10) @(posedge aclk);
    axi_write(CLK_SEL_OFS, 32'h0000_003E, RESP_OKAY, 4'h1);
    wait_stat(M_SRC, 5'b01000, 200);
    axi_write(CLK_SEL_OFS, 32'h0000_003F, RESP_OKAY, 4'h1);
    wait_stat(M_SRC, 5'b00000, 200);
    axi_write(CLK_SEL_OFS, 32'h0000_003D, RESP_OKAY, 4'h1);
    axi_write(CLK_SEL_OFS, 32'h0000_003F, RESP_OKAY, 4'h1);
    axi_read(CLK_SEL_OFS, rd, rr);
    check(rd, 32'h0000_007D);
    wait_stat(M_SRC, 5'b10000, 4000);
    axi_read(CLK_SEL_OFS, rd, rr);
    check(rd, 32'h0000_0035);
    axi_read(INT_STAT_OFS, rd, rr);
    check(rd & 32'h0000_0002, 32'h0000_0002);
    check(32'(irq), 32'h0000_0000);
    axi_write(INT_MASK_OFS, 32'h0000_0002, RESP_OKAY, 4'h1);
    check(32'(irq), 32'h0000_0001);
    axi_write(INT_STAT_OFS, 32'h0000_0003, RESP_OKAY, 4'h1);
    check(32'(irq), 32'h0000_0000);
    axi_write(CLK_SEL_OFS, 32'h0000_003F, RESP_OKAY, 4'h1);
    wait_stat(M_SRC, 5'b00000, 3000);
    check(32'(cyc >= 120), 32'h0000_0001);
    @(posedge aclk);
    check(32'(irq), 32'h0000_0001);
    axi_write(INT_STAT_OFS, 32'h0000_0003, RESP_OKAY, 4'h1);
    axi_write(LPM_CTRL_OFS, 32'h0000_0001, RESP_OKAY, 4'h1);
    wait_stat(5'b00001, 5'b00001, 200);
    repeat (20) @(posedge aclk);
    check(32'(clk_stat.stop_active), 32'h0000_0001);
    wake <= 1'b1;
    wait_stat(5'b11001, 5'b00000, 3000);
    wake <= 1'b0;
    axi_read(INT_STAT_OFS, rd, rr);
    check(rd & 32'h0000_0002, 32'h0000_0000);
    repeat (140) @(posedge aclk);
    axi_read(INT_STAT_OFS, rd, rr);
    check(rd & 32'h0000_0002, 32'h0000_0002);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_read(CLK_SEL_OFS, rd, rr);
    check(rd, 32'h0000_003F);
    print_verdict();
  end

  initial begin
    repeat (100000) @(posedge aclk);
    err_total++;
    print_verdict();
  end
endmodule : testbench
